/* rtl/fpeg_defs.svh */
`ifndef FPEG_DEFS_SVH
`define FPEG_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FPEG_OFS_PSC 4'h0
`define FPEG_OFS_KEY 4'h4
`define FPEG_OFS_RSS 4'h8
`define FPEG_OFS_STAT 4'hC
// ----------------------------------------
// field positions
// ----------------------------------------
`define FPEG_PSC_WE 0
`define FPEG_PSC_EE 1
`define FPEG_PSC_SCRATCHPAD_SELECT 2
`define FPEG_RSS_FERR 6
// ----------------------------------------
// values
// ----------------------------------------
`define FPEG_KEY1 8'hA5
`define FPEG_KEY2 8'hF1
`define FPEG_ERASED 8'hFF
`define FPEG_PSC_RST 3'h0
`define FPEG_LOCK_ADDR 16'hFBFF
`define FPEG_LOCK_PAGE 6'h3E
`define FPEG_RSVD_PAGE 6'h3F
`define FPEG_SHORT_TOP 16'h00FF
`define FPEG_SCR_TOP 16'h03FF
`define FPEG_PAGE_LAST 10'h3FF
`define FPEG_WIPE_LAST 17'h103FF
`define FPEG_ALL_BUT_SCR 8'h3E
// ----------------------------------------
// timing
// ----------------------------------------
`define FPEG_CLK_NS 100
`define FPEG_WR_NS 2000
`define FPEG_WR_CYC 16'((`FPEG_WR_NS + `FPEG_CLK_NS - 1) / `FPEG_CLK_NS)
`endif

/* rtl/fpeg_pkg.sv */
package fpeg_pkg;
  // key sequencer states; dead holds until system reset
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10,
    KEY_DEAD = 2'b11
  } fpeg_key_e;
  // operation sequencer states
  typedef enum logic [2:0] {
    OP_BOOT = 3'b000,
    OP_IDLE = 3'b001,
    OP_WRITE = 3'b010,
    OP_ERASE = 3'b011,
    OP_WIPE = 3'b100,
    OP_FAULT = 3'b101
  } fpeg_op_e;
  // debug port commands
  typedef enum logic [1:0] {
    DBG_READ = 2'b00,
    DBG_WRITE = 2'b01,
    DBG_ERASE = 2'b10,
    DBG_WIPE = 2'b11
  } fpeg_dbg_e;
endpackage : fpeg_pkg

/* rtl/fpeg_key.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fpeg_defs.svh"
module fpeg_key import fpeg_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic key_wr, // key register write
  input wire logic [7:0] key_data, // written key
  input wire logic attempt, // operation tried
  input wire logic done, // operation finished
  output fpeg_key_e key_state // lock state
);
  // ----------------------------------------
  // two-key lock
  // ----------------------------------------
  // a slip of any kind is fatal until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      key_state <= KEY_LOCKED;
    end else begin
      case (key_state)
        KEY_LOCKED: begin
          // an attempt beats a key written in the same cycle
          if (attempt) key_state <= KEY_DEAD;
          else if (key_wr && key_data == `FPEG_KEY1) key_state <= KEY_HALF;
          else if (key_wr) key_state <= KEY_DEAD;
        end
        KEY_HALF: begin
          if (attempt) key_state <= KEY_DEAD;
          else if (key_wr && key_data == `FPEG_KEY2) key_state <= KEY_OPEN;
          else if (key_wr) key_state <= KEY_DEAD;
        end
        KEY_OPEN: begin
          if (key_wr) key_state <= KEY_DEAD; // out of order
          else if (done) key_state <= KEY_LOCKED;
        end
        default: key_state <= KEY_DEAD;
      endcase
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_key_wrong: assert property (@(posedge clk) disable iff (rst)
    key_wr && key_state == KEY_LOCKED && key_data != `FPEG_KEY1 |=> key_state == KEY_DEAD)
    else $error("wrong first key did not block");
  a_key_dead: assert property (@(posedge clk) disable iff (rst)
    key_state == KEY_DEAD |=> key_state == KEY_DEAD)
    else $error("blocked lock reopened");
  a_key_relock: assert property (@(posedge clk) disable iff (rst)
    done && !key_wr |=> key_state != KEY_OPEN)
    else $error("lock left open after operation");
endmodule : fpeg_key
`default_nettype wire

/* rtl/fpeg_guard.sv */
// Operation
// - programming only clears bits; erase sets ones
// - operations self-timed, cpu stalled meanwhile
// - write-enable routes writes to flash, sticky
// - two keys in order, any spacing
// - wrong or misordered key blocks until reset
// - operation before keys blocks until reset
// - relock after each finished cpu operation
// - supply monitor off means error reset
// - erase write clears whole 1024-byte page
// - write needs we; erase needs we+ee
// - short-addressed writes cannot reach above 0xFF
// - external writes go to data ram while we is clear
// - scratchpad maps low for data only
// - lock byte complement locks first pages
// - lock page locked when any lock bit zero
// - debug denied locked areas, silently ignored
// - unlocked code touching locked areas resets
// - erase lock page or reprogram lock resets
// - new lock value acts after reset
// - reserved area refused always
// - error flag reads one after error reset
// - scratchpad locks with all pages; wipe clears
`timescale 1ns/1ps
`default_nettype none
`include "fpeg_defs.svh"
module fpeg_guard import fpeg_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic por, // power-on reset, clears error flag
  input wire logic [3:0] avs_address, // register byte address
  input wire logic avs_read, // bus read
  input wire logic avs_write, // bus write
  input wire logic [31:0] avs_writedata, // bus write data
  output logic [31:0] avs_readdata, // bus read data
  output logic avs_waitrequest, // bus stall
  input wire logic xm_wr, // external-move write
  input wire logic [15:0] xm_addr, // its address
  input wire logic [7:0] xm_data, // its data
  input wire logic xm_short, // 8-bit addressed form
  input wire logic [15:0] cpu_pc, // executing address
  input wire logic supmon_en, // supply monitor on
  input wire logic supmon_rst_src, // monitor is reset source
  output logic external_data_ram_wr, // write forwarded to data ram
  input wire logic cm_rd, // code-move read
  input wire logic [15:0] cm_addr, // its address
  output logic [7:0] cm_data, // its data
  input wire logic [15:0] fetch_addr, // instruction fetch address
  output logic [7:0] fetch_data, // fetched byte
  input wire logic dbg_req, // debug request, held to ack
  input wire logic [1:0] dbg_op, // debug command
  input wire logic [15:0] dbg_addr, // debug address
  input wire logic [7:0] dbg_wdata, // debug write data
  output logic dbg_ack, // debug done pulse
  output logic dbg_denied, // debug request refused
  output logic [7:0] dbg_rdata, // debug read data
  output logic cpu_stall, // hold execution
  output logic flash_error_reset // error reset pulse
);
  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [7:0] mem [0:65535]; // main flash
  logic [7:0] scr [0:1023]; // scratchpad
  fpeg_op_e state_r; // sequencer state
  fpeg_key_e key_state; // lock state
  logic [2:0] psc_r; // program store control
  logic ferr_r; // flash error flag
  logic [7:0] lock_cur_r; // lock value in force
  logic [15:0] cnt_r; // write timer
  logic [16:0] walk_r; // erase walker
  logic [15:0] op_addr_r; // target address
  logic [7:0] op_data_r; // target data
  logic op_scr_r; // target is scratchpad
  logic op_dbg_r; // debug owns operation
  logic pend_r; // held cpu write
  logic [15:0] pend_addr_r; // held address
  logic [7:0] pend_data_r; // held data
  logic pend_short_r; // held short form
  logic wait_r; // bus wait state
  logic key_attempt; // write tried
  logic key_done; // operation finished
  logic key_wr; // key register write
  logic bus_go; // bus access completes
  // ----------------------------------------
  // lock decode
  // ----------------------------------------
  logic [7:0] nlock; // locked page count
  logic any_locked; // lock page locked
  logic pc_locked; // code runs from locked page
  logic scr_locked; // scratchpad locked
  logic [15:0] rq_addr; // current cpu address
  logic [7:0] rq_data; // current cpu data
  logic rq_short; // current short form
  logic rq_valid; // cpu write waiting
  logic rq_flash; // cpu write bound for flash
  logic rq_scr; // cpu write hits scratchpad
  logic cm_scr; // read hits scratchpad
  logic dbg_scr; // debug hits scratchpad
  assign nlock = ~lock_cur_r;
  assign any_locked = nlock != 8'h00;
  assign scr_locked = nlock >= `FPEG_ALL_BUT_SCR;
  assign rq_addr = pend_r ? pend_addr_r : xm_addr;
  assign rq_data = pend_r ? pend_data_r : xm_data;
  assign rq_short = pend_r ? pend_short_r : xm_short;
  assign rq_valid = pend_r || xm_wr;
  assign rq_flash = psc_r[`FPEG_PSC_WE];
  assign rq_scr = psc_r[`FPEG_PSC_SCRATCHPAD_SELECT] && rq_addr <= `FPEG_SCR_TOP;
  assign cm_scr = psc_r[`FPEG_PSC_SCRATCHPAD_SELECT] && cm_addr <= `FPEG_SCR_TOP;
  assign dbg_scr = 1'b0; // debug sees main flash only
  assign key_wr = bus_go && avs_write && avs_address == `FPEG_OFS_KEY;
  // page locked for the given address
  function automatic logic tgt_locked(input logic [15:0] a, input logic s);
    logic [5:0] pg;
    pg = a[15:10];
    if (s) return scr_locked;
    return ({2'b00, pg} < nlock) || (pg == `FPEG_LOCK_PAGE && any_locked);
  endfunction : tgt_locked
  assign pc_locked = tgt_locked(cpu_pc, 1'b0);
  // firmware access refused; k: 0 read, 1 write, 2 erase
  function automatic logic fw_fault(input logic [15:0] a, input logic s, input logic [1:0] k);
    logic bad;
    bad = 1'b0;
    if (!s && a[15:10] == `FPEG_RSVD_PAGE) bad = 1'b1;
    if (!s && k == 2'd2 && a[15:10] == `FPEG_LOCK_PAGE) bad = 1'b1;
    if (!s && k == 2'd1 && a == `FPEG_LOCK_ADDR && mem[`FPEG_LOCK_ADDR] != `FPEG_ERASED)
      bad = 1'b1; // programmed lock byte is frozen
    if (!pc_locked && tgt_locked(a, s)) bad = 1'b1;
    return bad;
  endfunction : fw_fault
  // debug refusal: no reset, only a denied ack
  function automatic logic dbg_bad(input logic [15:0] a);
    return a[15:10] == `FPEG_RSVD_PAGE || tgt_locked(a, 1'b0);
  endfunction : dbg_bad
  // ----------------------------------------
  // key sequencer
  // ----------------------------------------
  fpeg_key u_key (
    .clk(clk),
    .rst(rst),
    .key_wr(key_wr),
    .key_data(avs_writedata[7:0]),
    .attempt(key_attempt),
    .done(key_done),
    .key_state(key_state)
  );
  // a flash-bound write in idle with monitor good but keys not open
  assign key_attempt = state_r == OP_IDLE && rq_valid && rq_flash && supmon_en
    && supmon_rst_src && !(rq_short && rq_addr > `FPEG_SHORT_TOP)
    && key_state != KEY_OPEN;
  assign key_done = !op_dbg_r && ((state_r == OP_WRITE && cnt_r == 16'h0000)
    || (state_r == OP_ERASE && walk_r[9:0] == `FPEG_PAGE_LAST));
  // ----------------------------------------
  // avalon slave
  // ----------------------------------------
  // one wait cycle, then the access completes
  assign bus_go = (avs_read || avs_write) && !wait_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_r) begin
      wait_r <= 1'b0;
      case (avs_address)
        `FPEG_OFS_PSC: avs_readdata <= {29'h0, psc_r};
        `FPEG_OFS_KEY: avs_readdata <= {30'h0, key_state};
        `FPEG_OFS_RSS: avs_readdata <= {25'h0, ferr_r, 6'h00};
        `FPEG_OFS_STAT: avs_readdata <= {23'h0, nlock, cpu_stall};
        default: avs_readdata <= 32'h0000_0000; // unmapped reads zero
      endcase
    end else begin
      wait_r <= 1'b1;
    end
  end
  assign avs_waitrequest = wait_r;
  // control bits change only by software
  always_ff @(posedge clk) begin
    if (rst) psc_r <= `FPEG_PSC_RST;
    else if (bus_go && avs_write && avs_address == `FPEG_OFS_PSC)
      psc_r <= avs_writedata[2:0];
  end
  // error flag survives the error reset, only power-on clears it
  always_ff @(posedge clk) begin
    if (por) ferr_r <= 1'b0;
    else if (state_r == OP_FAULT) ferr_r <= 1'b1;
  end
  // ----------------------------------------
  // pending cpu write
  // ----------------------------------------
  // a write that lands during a busy phase waits its turn
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= 1'b0;
      pend_addr_r <= 16'h0000;
      pend_data_r <= 8'h00;
      pend_short_r <= 1'b0;
    end else if (state_r == OP_IDLE) begin
      pend_r <= 1'b0;
    end else if (xm_wr && !pend_r) begin
      pend_r <= 1'b1;
      pend_addr_r <= xm_addr;
      pend_data_r <= xm_data;
      pend_short_r <= xm_short;
    end
  end
  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= OP_BOOT;
      lock_cur_r <= `FPEG_ERASED;
      cnt_r <= 16'h0000;
      walk_r <= 17'h00000;
      op_addr_r <= 16'h0000;
      op_data_r <= 8'h00;
      op_scr_r <= 1'b0;
      op_dbg_r <= 1'b0;
      cpu_stall <= 1'b1;
      flash_error_reset <= 1'b0;
      external_data_ram_wr <= 1'b0;
      cm_data <= 8'h00;
      dbg_ack <= 1'b0;
      dbg_denied <= 1'b0;
      dbg_rdata <= 8'h00;
    end else begin
      flash_error_reset <= 1'b0;
      external_data_ram_wr <= 1'b0;
      dbg_ack <= 1'b0;
      case (state_r)
        OP_BOOT: begin
          // lock value only sampled here, after reset release
          lock_cur_r <= mem[`FPEG_LOCK_ADDR];
          state_r <= OP_IDLE;
          cpu_stall <= 1'b0;
        end
        OP_IDLE: begin
          op_dbg_r <= 1'b0;
          if (rq_valid && !rq_flash) begin
            external_data_ram_wr <= 1'b1;
          end else if (rq_valid) begin
            op_addr_r <= rq_addr;
            op_data_r <= rq_data;
            op_scr_r <= rq_scr;
            walk_r <= {1'b0, rq_addr[15:10], 10'h000};
            cnt_r <= `FPEG_WR_CYC;
            if (rq_short && rq_addr > `FPEG_SHORT_TOP) begin
              state_r <= OP_IDLE; // dropped
            end else if (!supmon_en || !supmon_rst_src) begin
              state_r <= OP_FAULT;
              cpu_stall <= 1'b1;
            end else if (key_state != KEY_OPEN) begin
              state_r <= OP_IDLE; // refused
            end else if (fw_fault(rq_addr, rq_scr,
                psc_r[`FPEG_PSC_EE] ? 2'd2 : 2'd1)) begin
              state_r <= OP_FAULT;
              cpu_stall <= 1'b1;
            end else if (psc_r[`FPEG_PSC_EE]) begin
              state_r <= OP_ERASE;
              cpu_stall <= 1'b1;
            end else begin
              state_r <= OP_WRITE;
              cpu_stall <= 1'b1;
            end
          end else if (cm_rd) begin
            if (fw_fault(cm_addr, cm_scr, 2'd0)) begin
              state_r <= OP_FAULT;
              cpu_stall <= 1'b1;
            end else begin
              cm_data <= cm_scr ? scr[cm_addr[9:0]] : mem[cm_addr];
            end
          end else if (dbg_req && !dbg_ack) begin
            // ack still high: the host has not yet dropped the old request
            op_dbg_r <= 1'b1;
            op_addr_r <= dbg_addr;
            op_data_r <= dbg_wdata;
            op_scr_r <= dbg_scr;
            walk_r <= {1'b0, dbg_addr[15:10], 10'h000};
            cnt_r <= `FPEG_WR_CYC;
            cpu_stall <= 1'b1;
            if (dbg_op == DBG_WIPE) begin
              walk_r <= 17'h00000;
              state_r <= OP_WIPE;
            end else if (dbg_bad(dbg_addr)) begin
              dbg_ack <= 1'b1;
              dbg_denied <= 1'b1;
              cpu_stall <= 1'b0;
            end else if (dbg_op == DBG_READ) begin
              dbg_rdata <= mem[dbg_addr];
              dbg_ack <= 1'b1;
              dbg_denied <= 1'b0;
              cpu_stall <= 1'b0;
            end else if (dbg_op == DBG_ERASE) begin
              state_r <= OP_ERASE;
            end else begin
              state_r <= OP_WRITE;
            end
          end
        end
        OP_WRITE: begin
          // hold the cell for the programming time
          if (cnt_r == 16'h0000) begin
            state_r <= OP_IDLE;
            cpu_stall <= 1'b0;
            dbg_ack <= op_dbg_r;
            dbg_denied <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        OP_ERASE: begin
          // one byte per cycle across the page
          if (walk_r[9:0] == `FPEG_PAGE_LAST) begin
            state_r <= OP_IDLE;
            cpu_stall <= 1'b0;
            dbg_ack <= op_dbg_r;
            dbg_denied <= 1'b0;
          end else begin
            walk_r <= walk_r + 17'h00001;
          end
        end
        OP_WIPE: begin
          // all flash, then the scratchpad
          if (walk_r == `FPEG_WIPE_LAST) begin
            state_r <= OP_IDLE;
            lock_cur_r <= `FPEG_ERASED; // unlock all
            cpu_stall <= 1'b0;
            dbg_ack <= 1'b1;
            dbg_denied <= 1'b0;
          end else begin
            walk_r <= walk_r + 17'h00001;
          end
        end
        OP_FAULT: begin
          // error reset pulse; the system reset follows outside
          flash_error_reset <= 1'b1;
          state_r <= OP_IDLE;
        end
        default: state_r <= OP_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // array writes
  // ----------------------------------------
  // programming ands new data in, so bits only fall
  always_ff @(posedge clk) begin
    if (state_r == OP_WRITE && cnt_r == 16'h0000) begin
      if (op_scr_r) scr[op_addr_r[9:0]] <= scr[op_addr_r[9:0]] & op_data_r;
      else mem[op_addr_r] <= mem[op_addr_r] & op_data_r;
    end else if (state_r == OP_ERASE) begin
      if (op_scr_r) scr[walk_r[9:0]] <= `FPEG_ERASED;
      else mem[walk_r[15:0]] <= `FPEG_ERASED;
    end else if (state_r == OP_WIPE) begin
      if (walk_r[16]) scr[walk_r[9:0]] <= `FPEG_ERASED;
      else mem[walk_r[15:0]] <= `FPEG_ERASED;
    end
  end
  // fetches never see the scratchpad
  always_ff @(posedge clk) begin
    fetch_data <= mem[fetch_addr];
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_erase_start;
    state_r == OP_IDLE ##1 state_r == OP_ERASE;
  endsequence
  sequence s_fault_pulse;
    state_r == OP_FAULT ##1 flash_error_reset;
  endsequence
  a_erase_stall: assert property (@(posedge clk) disable iff (rst)
    s_erase_start |-> cpu_stall && walk_r[9:0] == 10'h000)
    else $error("erase began unstalled or mid-page");
  a_erase_end: assert property (@(posedge clk) disable iff (rst)
    state_r == OP_ERASE && walk_r[9:0] == `FPEG_PAGE_LAST |=> state_r == OP_IDLE && !cpu_stall)
    else $error("erase did not end at page top");
  a_write_time: assert property (@(posedge clk) disable iff (rst)
    state_r == OP_IDLE ##1 state_r == OP_WRITE |-> cpu_stall [*8])
    else $error("stall dropped during write");
  a_supmon_fault: assert property (@(posedge clk) disable iff (rst)
    state_r == OP_IDLE && rq_valid && rq_flash && !rq_short && (!supmon_en || !supmon_rst_src)
    |=> s_fault_pulse)
    else $error("no error reset with monitor off");
  a_ferr_flag: assert property (@(posedge clk) disable iff (rst || por)
    flash_error_reset |-> ferr_r)
    else $error("error flag not set");
  a_short_drop: assert property (@(posedge clk) disable iff (rst)
    state_r == OP_IDLE && rq_valid && rq_short && rq_addr > `FPEG_SHORT_TOP
    |=> state_r == OP_IDLE)
    else $error("short write reached high flash");
  a_dbg_quiet: assert property (@(posedge clk) disable iff (rst)
    state_r == OP_IDLE && !rq_valid && !cm_rd && dbg_req && !dbg_ack && dbg_op != DBG_WIPE
    && dbg_bad(dbg_addr) |=> dbg_ack && dbg_denied && !flash_error_reset ##1 !flash_error_reset)
    else $error("denied debug request not ignored");
  a_nokey_refuse: assert property (@(posedge clk) disable iff (rst)
    key_attempt |=> state_r == OP_IDLE && key_state == KEY_DEAD)
    else $error("keyless operation not blocked");
endmodule : fpeg_guard
`default_nettype wire

/* testbench/fpeg_dbg_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// debug programmer model
// ----------------------------------------
module fpeg_dbg_host (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic go, // start one command
  input wire logic [1:0] op_in, // command to issue
  input wire logic [15:0] addr_in, // address to issue
  input wire logic [7:0] wdata_in, // data to issue
  input wire logic dbg_ack, // done pulse from guard
  output logic dbg_req, // request, held to ack
  output logic [1:0] dbg_op, // command
  output logic [15:0] dbg_addr, // address
  output logic [7:0] dbg_wdata // write data
);
  // request stays put until ack is seen; released address and data lines flip so a stale
  // value can never pass for a fresh one
  always_ff @(posedge clk) begin
    if (rst) begin
      dbg_req <= 1'b0;
      dbg_op <= 2'h0;
      dbg_addr <= 16'h0000;
      dbg_wdata <= 8'h00;
    end else if (go && !dbg_req) begin
      dbg_req <= 1'b1;
      dbg_op <= op_in;
      dbg_addr <= addr_in;
      dbg_wdata <= wdata_in;
    end else if (dbg_req && dbg_ack) begin
      dbg_req <= 1'b0;
      dbg_addr <= ~dbg_addr;
      dbg_wdata <= ~dbg_wdata;
    end
  end
endmodule : fpeg_dbg_host
`default_nettype wire

/* testbench/flash_program_erase_guard_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_guard_bench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 0, rst = 1, por = 1, aw = 0, ar = 0, xw = 0, xs = 0, sen = 1, cr = 0, go = 0;
  logic [3:0] aa = 0;
  logic [31:0] awd = 0, q;
  logic [15:0] xa = 0, ca = 0, fa = 0, gad = 0, a, pc = 16'h2000;
  logic [7:0] xd = 0, gwd = 0, v;
  logic [1:0] gop = 0;
  logic fer_seen = 0, xr_seen = 0, srs = 1; // sticky pulse flags; monitor reset source
  wire [31:0] ard;
  wire [15:0] dad;
  wire [7:0] cd, fd, drd, dwd;
  wire [1:0] dop;
  wire wrq, external_data_ram, dack, dden, stall, fer, dreq;
  int err_total = 0, n_checks = 0;
  logic [7:0] mem [int]; // flash model, absent means erased
  fpeg_guard dut_u (.clk(clk), .rst(rst), .por(por), .avs_address(aa), .avs_read(ar),
    .avs_write(aw), .avs_writedata(awd), .avs_readdata(ard), .avs_waitrequest(wrq),
    .xm_wr(xw), .xm_addr(xa), .xm_data(xd), .xm_short(xs), .cpu_pc(pc),
    .supmon_en(sen), .supmon_rst_src(srs), .external_data_ram_wr(external_data_ram), .cm_rd(cr), .cm_addr(ca),
    .cm_data(cd), .fetch_addr(fa), .fetch_data(fd), .dbg_req(dreq), .dbg_op(dop),
    .dbg_addr(dad), .dbg_wdata(dwd), .dbg_ack(dack), .dbg_denied(dden), .dbg_rdata(drd),
    .cpu_stall(stall), .flash_error_reset(fer));
  fpeg_dbg_host host_u (.clk(clk), .rst(rst), .go(go), .op_in(gop), .addr_in(gad),
    .wdata_in(gwd), .dbg_ack(dack), .dbg_req(dreq), .dbg_op(dop), .dbg_addr(dad),
    .dbg_wdata(dwd));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (fer === 1'b1) fer_seen <= 1'b1;
    if (external_data_ram === 1'b1) xr_seen <= 1'b1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] ex(input logic [15:0] ad);
    return mem.exists(int'(ad)) ? mem[int'(ad)] : 8'hFF;
  endfunction : ex
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one bus cycle; held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    aa <= ad; awd <= d; aw <= w; ar <= !w;
    do @(posedge clk); while (wrq !== 1'b0);
    q = ard;
    aw <= 1'b0; ar <= 1'b0;
  endtask : bus
  task keys;
    bus(1, 4'h4, 32'hA5);
    bus(1, 4'h4, 32'hF1);
  endtask : keys
  // cpu move write, then wait out the stall or the error pulse
  task xmop(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk);
    xa <= ad; xd <= d; xw <= 1'b1;
    @(posedge clk);
    xw <= 1'b0;
    do @(negedge clk); while (stall !== 1'b0 && fer !== 1'b1);
  endtask : xmop
  // code-move read and fetch of one address, both against the model
  task cmr(input logic [15:0] ad);
    @(posedge clk);
    cr <= 1'b1; ca <= ad; fa <= ad;
    @(posedge clk);
    cr <= 1'b0;
    @(negedge clk);
    chk(cd, ex(ad));
    chk(fd, ex(ad));
  endtask : cmr
  task dbg(input logic [1:0] op, input logic [15:0] ad);
    @(posedge clk);
    gop <= op; gad <= ad; gwd <= 8'h00; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(negedge clk); while (dack !== 1'b1);
  endtask : dbg
  task rstp;
    @(posedge clk); rst <= 1'b1;
    cyc(2); rst <= 1'b0;
    cyc(2);
  endtask : rstp
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(80468));
    cyc(2); rst <= 1'b0; por <= 1'b0;
    cyc(2);
    dbg(2'h3, 16'h0000); chk(dden, 0);
    bus(0, 4'h8, 0); chk(q[6], 0);
    xmop(16'h0400, 8'h00); cyc(2); chk(xr_seen, 1);
    bus(1, 4'h0, 32'h1); bus(0, 4'h0, 0); chk(q[2:0], 3'h1);
    a = 16'h0400 | 16'($urandom % 1024);
    repeat (3) begin
      v = 8'($urandom);
      bus(1, 4'h4, 32'hA5); bus(0, 4'h4, 0); chk(q, 32'h1);
      bus(1, 4'h4, 32'hF1); bus(0, 4'h4, 0); chk(q, 32'h2);
      xmop(a, v); mem[int'(a)] = ex(a) & v;
      cmr(a);
      bus(0, 4'h4, 0); chk(q, 32'h0);
    end
    dbg(2'h0, a); chk(drd, ex(a));
    bus(1, 4'h0, 32'h3); keys;
    xmop(16'h0400 | 16'($urandom % 1024), 8'($urandom));
    for (int k = 16'h0400; k < 16'h0800; k++) mem.delete(k);
    cmr(a);
    v = 8'($urandom); bus(1, 4'h0, 32'h1); sen <= v[0]; srs <= !v[0]; keys;
    xmop(16'h0800, 8'h00); cyc(4);
    chk(fer_seen, 1);
    bus(0, 4'h8, 0); chk(q[6], 1);
    sen <= 1'b1; srs <= 1'b1; rstp;
    bus(0, 4'h8, 0); chk(q[6], 1);
    cmr(16'h0800);
    bus(1, 4'h0, 32'h1); keys; xs <= 1'b1;
    xmop(16'h0C00, 8'h00); xs <= 1'b0;
    cmr(16'h0C00);
    rstp; bus(1, 4'h0, 32'h1); xmop(16'h0C00, 8'h00);
    bus(0, 4'h4, 0); chk(q, 32'h3);
    rstp; bus(1, 4'h4, 32'h5A); keys;
    bus(0, 4'h4, 0); chk(q, 32'h3);
    rstp; bus(1, 4'h0, 32'h1); keys;
    xmop(16'hFBFF, 8'hFE); mem[int'(16'hFBFF)] = 8'hFE;
    dbg(2'h0, 16'h0010); chk(dden, 0); chk(drd, ex(16'h0010));
    rstp; dbg(2'h0, 16'h0010); chk(dden, 1);
    pc <= 16'h0000; cmr(16'h0010); pc <= 16'h2000;
    print_verdict;
  end
  // watchdog: the wipe dominates the run time
  initial begin
    cyc(90000);
    err_total++;
    print_verdict;
  end
endmodule : flash_program_erase_guard_bench
`default_nettype wire
